// ---- src/pcr_pkg.sv ----
/*
 * constants for the port pin configuration block: sfr addresses, pages,
 * reset values, bit positions and the port 1 output mode encoding.
 * assumes a byte wide sfr bus and a page select bit kept by the cpu core.
 */
package pcr_pkg;

    // ****************************************
    // sfr addresses
    // ****************************************
    localparam logic [7:0] PCR_ADDR_SLEW0  = 8'hB2;   // port 0 slew, page 1
    localparam logic [7:0] PCR_ADDR_P1_A   = 8'hB3;   // mode select a (page 0) / input type (page 1)
    localparam logic [7:0] PCR_ADDR_P1_B   = 8'hB4;   // mode select b (page 0) / slew (page 1)
    localparam logic [7:0] PCR_ADDR_PIN20  = 8'hB5;   // pin 2.0 and timer output config, no page

    // ****************************************
    // page values
    // ****************************************
    localparam logic PCR_PAGE0 = 1'b0;
    localparam logic PCR_PAGE1 = 1'b1;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] PCR_RST_SLEW0   = 8'h00;
    localparam logic [7:0] PCR_RST_MODE_A  = 8'hFF;
    localparam logic [7:0] PCR_RST_MODE_B  = 8'h00;
    localparam logic [7:0] PCR_RST_ITYPE   = 8'h00;
    localparam logic [7:0] PCR_RST_SLEW1   = 8'h00;
    localparam logic [7:0] PCR_RST_PIN20   = 8'h00;
    localparam logic [7:0] PCR_RDATA_NONE  = 8'h00;   // unmapped or idle read data

    // ****************************************
    // pin 2.0 config register fields
    // ****************************************
    localparam int PCR_BIT_SCHMITT  = 0;
    localparam int PCR_BIT_T0_OE    = 2;
    localparam int PCR_BIT_T1_OE    = 3;
    localparam int PCR_BIT_PULLUP   = 7;
    localparam logic [7:0] PCR_PIN20_MASK = 8'h8D;    // implemented bits, rest read zero

    // ****************************************
    // output mode encoding, {sel_a, sel_b}
    // ****************************************
    typedef enum logic [1:0] {
        PCR_MODE_QUASI = 2'b00,
        PCR_MODE_PUSH  = 2'b01,
        PCR_MODE_HIZ   = 2'b10,
        PCR_MODE_OPEN  = 2'b11
    } pcr_mode_e;

endpackage : pcr_pkg

// ---- src/pcr_mode_if.sv ----
/*
 * carrier between the register block and the port 1 mode decoder.
 * assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps

interface pcr_mode_if;
    logic [7:0] sel_a;        // first mode select byte
    logic [7:0] sel_b;        // second mode select byte
    logic [7:0] quasi;        // pin is quasi-bidirectional
    logic [7:0] push_pull;    // pin is push-pull
    logic [7:0] input_only;   // pin is high-impedance input
    logic [7:0] open_drain;   // pin is open-drain

    modport cfg (output sel_a, output sel_b,
                 input quasi, input push_pull, input input_only, input open_drain);
    modport dec (input sel_a, input sel_b,
                 output quasi, output push_pull, output input_only, output open_drain);
endinterface : pcr_mode_if

// ---- src/pcr_mode_decode.sv ----
/*
 * decodes the two mode select bytes into one-hot per pin output structure.
 * assumes select bytes come from registers on the same clock.
 */
`timescale 1ns/1ps

module pcr_mode_decode (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    // mode bytes in, decoded structure out
    pcr_mode_if.dec   mode
);
    import pcr_pkg::*;

    // ****************************************
    // per pin decode
    // ****************************************
    // registered so the pad control lines never glitch during a write
    genvar n;
    generate
        for (n = 0; n < 8; n++) begin : g_pin
            pcr_mode_e pin_mode;   // combined mode of this pin
            assign pin_mode = pcr_mode_e'({mode.sel_a[n], mode.sel_b[n]});

            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    // matches the reset bytes: every pin high impedance
                    mode.quasi[n]      <= 1'b0;
                    mode.push_pull[n]  <= 1'b0;
                    mode.input_only[n] <= 1'b1;
                    mode.open_drain[n] <= 1'b0;
                end else begin
                    mode.quasi[n]      <= (pin_mode == PCR_MODE_QUASI);
                    mode.push_pull[n]  <= (pin_mode == PCR_MODE_PUSH);
                    mode.input_only[n] <= (pin_mode == PCR_MODE_HIZ);
                    mode.open_drain[n] <= (pin_mode == PCR_MODE_OPEN);
                end
            end
        end
    endgenerate

endmodule : pcr_mode_decode

// ---- src/pcr_port_cfg.sv ----
/*
 * port pin configuration registers: slew rate for ports 0 and 1, port 1
 * output mode and input type, pin 2.0 input type and pull-up, and the timer
 * 0 and 1 pin output enables. reached over the byte wide sfr bus.
 * assumes the cpu core holds the page select bit and drives single cycle
 * read and write strobes on clk_sys; the reset-pin-disable fuse bit is an
 * asynchronous level.
 */
`timescale 1ns/1ps

// Summary of operation
// - port 0 slew bit high means fast edge
// - port 1 slew bit high means fast edge
// - two mode bytes combine per port 1 pin
// - 00 quasi, 01 push, 10 hiz, 11 open-drain
// - reset leaves every port 1 pin high impedance
// - port 1 input type bit selects schmitt
// - pin 2.0 bit 0 selects schmitt input
// - pin 2.0 pull-up bit obeyed only without fuse
// - bit 3 routes timer 1 to its pin
// - bit 2 routes timer 0 to its pin
// - B3 and B4 split registers by page
module pcr_port_cfg (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // sfr bus
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_page,
    output logic      [7:0] sfr_rdata,
    // configuration fuse and timer toggles
    input  wire logic       reset_pin_disable,
    input  wire logic       timer0_toggle,
    input  wire logic       timer1_toggle,
    // port 0 pad control
    output logic      [7:0] port0_fast_slew,
    // port 1 pad control
    output logic      [7:0] port1_fast_slew,
    output logic      [7:0] port1_schmitt,
    output logic      [7:0] port1_quasi,
    output logic      [7:0] port1_push_pull,
    output logic      [7:0] port1_input_only,
    output logic      [7:0] port1_open_drain,
    // pin 2.0 pad control
    output logic            pin20_schmitt,
    output logic            pin20_pullup,
    // timer pins
    output logic            timer0_pin_out,
    output logic            timer0_pin_oe,
    output logic            timer1_pin_out,
    output logic            timer1_pin_oe
);
    import pcr_pkg::*;

    // ****************************************
    // register storage
    // ****************************************
    logic [7:0] port0_slew_ctrl_reg;          // port 0 slew
    logic [7:0] port1_mode_sel_a_reg;         // port 1 mode select a
    logic [7:0] port1_mode_sel_b_reg;         // port 1 mode select b
    logic [7:0] port1_input_type_reg;         // port 1 schmitt select
    logic [7:0] port1_slew_ctrl_reg;          // port 1 slew
    logic [7:0] pin20_timer_output_cfg_reg;   // pin 2.0 and timer config
    logic [7:0] sfr_rdata_reg;                // registered read data
    logic [7:0] sfr_rdata_next;               // read mux
    logic       fuse_meta_reg;                // fuse sync stage 1
    logic       fuse_sync_reg;                // fuse sync stage 2
    logic       pin20_schmitt_reg;
    logic       pin20_pullup_reg;
    logic [7:0] port0_fast_slew_reg;
    logic [7:0] port1_fast_slew_reg;
    logic [7:0] port1_schmitt_reg;
    logic       timer0_pin_out_reg;
    logic       timer0_pin_oe_reg;
    logic       timer1_pin_out_reg;
    logic       timer1_pin_oe_reg;

    // ****************************************
    // write decode
    // ****************************************
    logic wr_slew0;     // port 0 slew write
    logic wr_mode_a;    // mode select a write
    logic wr_itype;     // input type write
    logic wr_mode_b;    // mode select b write
    logic wr_slew1;     // port 1 slew write
    logic wr_pin20;     // pin 2.0 config write

    // the page bit picks one of two registers at each shared address
    always_comb begin
        wr_slew0  = 1'b0;
        wr_mode_a = 1'b0;
        wr_itype  = 1'b0;
        wr_mode_b = 1'b0;
        wr_slew1  = 1'b0;
        wr_pin20  = 1'b0;
        if (!sfr_wr) begin
            // idle, nothing written
        end else if (sfr_addr == PCR_ADDR_SLEW0 && sfr_page == PCR_PAGE1) begin
            wr_slew0 = 1'b1;
        end else if (sfr_addr == PCR_ADDR_P1_A) begin
            wr_mode_a = (sfr_page == PCR_PAGE0);
            wr_itype  = (sfr_page == PCR_PAGE1);
        end else if (sfr_addr == PCR_ADDR_P1_B) begin
            wr_mode_b = (sfr_page == PCR_PAGE0);
            wr_slew1  = (sfr_page == PCR_PAGE1);
        end else if (sfr_addr == PCR_ADDR_PIN20) begin
            wr_pin20 = 1'b1;   // no page split here
        end
    end

    // ****************************************
    // register writes
    // ****************************************
    // port 0 page 0 at B2 belongs to another block, only page 1 is ours
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            port0_slew_ctrl_reg        <= PCR_RST_SLEW0;
            port1_mode_sel_a_reg       <= PCR_RST_MODE_A;
            port1_mode_sel_b_reg       <= PCR_RST_MODE_B;
            port1_input_type_reg       <= PCR_RST_ITYPE;
            port1_slew_ctrl_reg        <= PCR_RST_SLEW1;
            pin20_timer_output_cfg_reg <= PCR_RST_PIN20;
        end else begin
            if (wr_slew0)  port0_slew_ctrl_reg  <= sfr_wdata;
            if (wr_mode_a) port1_mode_sel_a_reg <= sfr_wdata;
            if (wr_itype)  port1_input_type_reg <= sfr_wdata;
            if (wr_mode_b) port1_mode_sel_b_reg <= sfr_wdata;
            if (wr_slew1)  port1_slew_ctrl_reg  <= sfr_wdata;
            // unimplemented bits are never stored, so they read back zero
            if (wr_pin20)  pin20_timer_output_cfg_reg <= sfr_wdata & PCR_PIN20_MASK;
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        sfr_rdata_next = PCR_RDATA_NONE;
        if (!sfr_rd) begin
            sfr_rdata_next = PCR_RDATA_NONE;
        end else if (sfr_addr == PCR_ADDR_SLEW0 && sfr_page == PCR_PAGE1) begin
            sfr_rdata_next = port0_slew_ctrl_reg;
        end else if (sfr_addr == PCR_ADDR_P1_A) begin
            sfr_rdata_next = (sfr_page == PCR_PAGE1) ? port1_input_type_reg : port1_mode_sel_a_reg;
        end else if (sfr_addr == PCR_ADDR_P1_B) begin
            sfr_rdata_next = (sfr_page == PCR_PAGE1) ? port1_slew_ctrl_reg : port1_mode_sel_b_reg;
        end else if (sfr_addr == PCR_ADDR_PIN20) begin
            sfr_rdata_next = pin20_timer_output_cfg_reg;
        end
    end

    // read data lands one edge after the strobe and clears when idle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) sfr_rdata_reg <= PCR_RDATA_NONE;
        else        sfr_rdata_reg <= sfr_rdata_next;
    end

    // ****************************************
    // fuse synchroniser
    // ****************************************
    // fuse level is async; resets to the reset pin role so the pull-up never dips while syncing
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fuse_meta_reg <= 1'b1;
            fuse_sync_reg <= 1'b1;
        end else begin
            fuse_meta_reg <= reset_pin_disable;
            fuse_sync_reg <= fuse_meta_reg;
        end
    end

    // ****************************************
    // pad control outputs
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            port0_fast_slew_reg <= PCR_RST_SLEW0;
            port1_fast_slew_reg <= PCR_RST_SLEW1;
            port1_schmitt_reg   <= PCR_RST_ITYPE;
            pin20_schmitt_reg   <= 1'b0;
            pin20_pullup_reg    <= 1'b1;   // reset pin role: pull-up on
        end else begin
            port0_fast_slew_reg <= port0_slew_ctrl_reg;
            port1_fast_slew_reg <= port1_slew_ctrl_reg;
            port1_schmitt_reg   <= port1_input_type_reg;
            pin20_schmitt_reg   <= pin20_timer_output_cfg_reg[PCR_BIT_SCHMITT];
            // while the pin is the reset input the pull-up cannot be turned off
            pin20_pullup_reg    <= fuse_sync_reg ? 1'b1 : pin20_timer_output_cfg_reg[PCR_BIT_PULLUP];
        end
    end

    // ****************************************
    // timer pin routing
    // ****************************************
    // counter mode use is left to software, the enable is obeyed as written
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            timer0_pin_out_reg <= 1'b0;
            timer0_pin_oe_reg  <= 1'b0;
            timer1_pin_out_reg <= 1'b0;
            timer1_pin_oe_reg  <= 1'b0;
        end else begin
            timer0_pin_oe_reg  <= pin20_timer_output_cfg_reg[PCR_BIT_T0_OE];
            timer0_pin_out_reg <= timer0_toggle & pin20_timer_output_cfg_reg[PCR_BIT_T0_OE];
            timer1_pin_oe_reg  <= pin20_timer_output_cfg_reg[PCR_BIT_T1_OE];
            timer1_pin_out_reg <= timer1_toggle & pin20_timer_output_cfg_reg[PCR_BIT_T1_OE];
        end
    end

    // ****************************************
    // port 1 mode decoder
    // ****************************************
    pcr_mode_if mode_bus ();

    assign mode_bus.sel_a = port1_mode_sel_a_reg;
    assign mode_bus.sel_b = port1_mode_sel_b_reg;

    pcr_mode_decode u_mode_decode (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .mode    (mode_bus.dec)
    );

    // ****************************************
    // output assignment
    // ****************************************
    assign sfr_rdata        = sfr_rdata_reg;
    assign port0_fast_slew  = port0_fast_slew_reg;
    assign port1_fast_slew  = port1_fast_slew_reg;
    assign port1_schmitt    = port1_schmitt_reg;
    assign port1_quasi      = mode_bus.quasi;
    assign port1_push_pull  = mode_bus.push_pull;
    assign port1_input_only = mode_bus.input_only;
    assign port1_open_drain = mode_bus.open_drain;
    assign pin20_schmitt    = pin20_schmitt_reg;
    assign pin20_pullup     = pin20_pullup_reg;
    assign timer0_pin_out   = timer0_pin_out_reg;
    assign timer0_pin_oe    = timer0_pin_oe_reg;
    assign timer1_pin_out   = timer1_pin_out_reg;
    assign timer1_pin_oe    = timer1_pin_oe_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    chk_slew0_path: assert property (
        (sfr_wr && sfr_addr == PCR_ADDR_SLEW0 && sfr_page == PCR_PAGE1)
            |-> ##2 port0_fast_slew == $past(sfr_wdata, 2))
        else $error("port 0 slew did not follow write");

    chk_slew1_path: assert property (
        (sfr_wr && sfr_addr == PCR_ADDR_P1_B && sfr_page == PCR_PAGE1)
            |-> ##2 port1_fast_slew == $past(sfr_wdata, 2))
        else $error("port 1 slew did not follow write");

    chk_mode_decode: assert property (
        ##1 port1_push_pull == $past(~port1_mode_sel_a_reg & port1_mode_sel_b_reg)
            && port1_open_drain == $past(port1_mode_sel_a_reg & port1_mode_sel_b_reg))
        else $error("port 1 mode decode wrong");

    chk_mode_write_page: assert property (
        (sfr_wr && sfr_addr == PCR_ADDR_P1_A && sfr_page == PCR_PAGE0)
            |=> port1_mode_sel_a_reg == $past(sfr_wdata) && $stable(port1_input_type_reg))
        else $error("page 0 write at B3 misrouted");

    chk_mode_reset: assert property (
        $rose(rst_b) |-> port1_input_only == 8'hFF && port1_mode_sel_a_reg == PCR_RST_MODE_A)
        else $error("port 1 not high impedance after reset");

    chk_itype_path: assert property (
        (sfr_wr && sfr_addr == PCR_ADDR_P1_A && sfr_page == PCR_PAGE1)
            |-> ##2 port1_schmitt == $past(sfr_wdata, 2))
        else $error("port 1 input type did not follow write");

    chk_pin20_schmitt: assert property (
        ##1 pin20_schmitt == $past(pin20_timer_output_cfg_reg[PCR_BIT_SCHMITT]))
        else $error("pin 2.0 schmitt select wrong");

    chk_pullup_fuse: assert property (
        fuse_sync_reg |=> pin20_pullup)
        else $error("pull-up off while pin is reset input");

    chk_pullup_soft: assert property (
        !fuse_sync_reg |=> pin20_pullup == $past(pin20_timer_output_cfg_reg[PCR_BIT_PULLUP]))
        else $error("pull-up ignores its enable bit");

    chk_timer0_route: assert property (
        !pin20_timer_output_cfg_reg[PCR_BIT_T0_OE] |=> !timer0_pin_oe && !timer0_pin_out)
        else $error("timer 0 pin driven while disabled");

    chk_timer1_route: assert property (
        pin20_timer_output_cfg_reg[PCR_BIT_T1_OE] |=> timer1_pin_oe && timer1_pin_out == $past(timer1_toggle))
        else $error("timer 1 pin not following timer");

endmodule : pcr_port_cfg

// ---- dv/pcr_board_model.sv ----
/*
 * board side of the pin configuration block: fuse level, timer toggle
 * sources and the two timer pads with their board pull-downs.
 * assumes the bench sets the wanted levels; all changes follow clk_sys.
 */
`timescale 1ns/1ps

module pcr_board_model (
    // clock
    input  wire logic clk_sys,
    // levels wanted by the bench
    input  wire logic fuse_lvl,
    input  wire logic t0_lvl,
    input  wire logic t1_lvl,
    // timer pin drive from the block
    input  wire logic t0_out,
    input  wire logic t0_oe,
    input  wire logic t1_out,
    input  wire logic t1_oe,
    // towards the block and the pads
    output logic      reset_pin_disable,
    output logic      timer0_toggle,
    output logic      timer1_toggle,
    output wire logic t0_pad,
    output wire logic t1_pad
);
    // ************************************
    // sources
    // ************************************
    // timers run in timer mode only, so enabling their pins is legal
    always_ff @(posedge clk_sys) begin
        reset_pin_disable <= fuse_lvl;
        timer0_toggle     <= t0_lvl;
        timer1_toggle     <= t1_lvl;
    end
    // released pads fall to the board pull-down, never hold the last value
    assign t0_pad = t0_oe ? t0_out : 1'b0;
    assign t1_pad = t1_oe ? t1_out : 1'b0;
endmodule : pcr_board_model

// ---- dv/test_port_pin_config_regs.sv ----
/*
 * self-checking bench for the port pin configuration block.
 * assumes single cycle sfr strobes and registered pad outputs.
 */
`timescale 1ns/1ps

`define CHK(nm, exp, got) if ((got) !== (exp)) begin $display("mismatch %s exp %h got %h", nm, exp, got); error_cnt++; end total_checks++;

module test_port_pin_config_regs;
    import pcr_pkg::*;
    // ************************************
    // signals
    // ************************************
    logic       clk_sys, rst_b;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic       sfr_wr, sfr_rd, sfr_page;
    logic       fuse_lvl, t0_lvl, t1_lvl, fuse_pin, tg0, tg1, t0_pad, t1_pad;
    logic [7:0] fs0, fs1, schm1, quasi, push, hiz, odr;
    logic       schm20, pull20, t0o, t0e, t1o, t1e;
    int         error_cnt, total_checks, cycles;

    pcr_port_cfg dut (.clk_sys(clk_sys), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_page(sfr_page), .sfr_rdata(sfr_rdata),
        .reset_pin_disable(fuse_pin), .timer0_toggle(tg0), .timer1_toggle(tg1),
        .port0_fast_slew(fs0), .port1_fast_slew(fs1), .port1_schmitt(schm1),
        .port1_quasi(quasi), .port1_push_pull(push), .port1_input_only(hiz),
        .port1_open_drain(odr), .pin20_schmitt(schm20), .pin20_pullup(pull20),
        .timer0_pin_out(t0o), .timer0_pin_oe(t0e), .timer1_pin_out(t1o), .timer1_pin_oe(t1e));

    pcr_board_model board (.clk_sys(clk_sys), .fuse_lvl(fuse_lvl), .t0_lvl(t0_lvl), .t1_lvl(t1_lvl),
        .t0_out(t0o), .t0_oe(t0e), .t1_out(t1o), .t1_oe(t1e), .reset_pin_disable(fuse_pin),
        .timer0_toggle(tg0), .timer1_toggle(tg1), .t0_pad(t0_pad), .t1_pad(t1_pad));

    // ************************************
    // clock and hang guard
    // ************************************
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // the whole run needs under a hundred cycles; 5000 means a hang
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // ************************************
    // bus tasks
    // ************************************
    task automatic wr(input logic pg, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_wr <= 1'b1; sfr_page <= pg; sfr_addr <= a; sfr_wdata <= d;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        // pads follow one edge after the register
        @(posedge clk_sys);
        #1;
    endtask : wr

    task automatic rd_chk(input string nm, input logic pg, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        sfr_rd <= 1'b1; sfr_page <= pg; sfr_addr <= a;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1;
        `CHK(nm, e, sfr_rdata)
    endtask : rd_chk

    task automatic tally_and_finish();
        if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    // ************************************
    // scenarios
    // ************************************
    // every register and the port 1 mode outputs at their reset values
    task automatic t_reset();
        rd_chk("slew0", PCR_PAGE1, 8'hB2, 8'h00);
        rd_chk("mode_a", PCR_PAGE0, 8'hB3, 8'hFF);
        rd_chk("itype", PCR_PAGE1, 8'hB3, 8'h00);
        rd_chk("mode_b", PCR_PAGE0, 8'hB4, 8'h00);
        rd_chk("slew1", PCR_PAGE1, 8'hB4, 8'h00);
        rd_chk("pin20", PCR_PAGE0, 8'hB5, 8'h00);
        `CHK("hiz_rst", 8'hFF, hiz)
        `CHK("quasi_rst", 8'h00, quasi | push | odr)
    endtask : t_reset

    // port 0 slew lives on page 1 only; page 0 of that address is not ours
    task automatic t_slew0();
        wr(PCR_PAGE1, 8'hB2, 8'h5A);
        `CHK("fs0", 8'h5A, fs0)
        wr(PCR_PAGE0, 8'hB2, 8'hFF);
        rd_chk("slew0_keep", PCR_PAGE1, 8'hB2, 8'h5A);
        rd_chk("unmapped", PCR_PAGE0, 8'hB6, 8'h00);
    endtask : t_slew0

    // shared addresses, all four mode codes across the pins
    task automatic t_port1();
        logic [7:0] a, b;
        a = 8'hCC;
        b = 8'hAA;
        wr(PCR_PAGE0, 8'hB3, a);
        wr(PCR_PAGE1, 8'hB3, 8'h3C);
        wr(PCR_PAGE0, 8'hB4, b);
        wr(PCR_PAGE1, 8'hB4, 8'h96);
        `CHK("quasi", ~a & ~b, quasi)
        `CHK("push", ~a & b, push)
        `CHK("hiz", a & ~b, hiz)
        `CHK("odr", a & b, odr)
        `CHK("schm1", 8'h3C, schm1)
        `CHK("fs1", 8'h96, fs1)
        rd_chk("mode_a_rb", PCR_PAGE0, 8'hB3, a);
        rd_chk("itype_rb", PCR_PAGE1, 8'hB3, 8'h3C);
        rd_chk("mode_b_rb", PCR_PAGE0, 8'hB4, b);
        rd_chk("slew1_rb", PCR_PAGE1, 8'hB4, 8'h96);
    endtask : t_port1

    // pin 2.0 input type, pull-up with and without the fuse
    task automatic t_pin20();
        wr(PCR_PAGE0, 8'hB5, 8'hFF);
        rd_chk("pin20_rb", PCR_PAGE0, 8'hB5, 8'h8D);
        `CHK("schm20", 1'b1, schm20)
        `CHK("pull_on", 1'b1, pull20)
        wr(PCR_PAGE1, 8'hB5, 8'h0C);
        `CHK("schm20_off", 1'b0, schm20)
        `CHK("pull_off", 1'b0, pull20)
        fuse_lvl <= 1'b1;
        repeat (5) @(posedge clk_sys);
        #1;
        `CHK("pull_forced", 1'b1, pull20)
        fuse_lvl <= 1'b0;
        repeat (5) @(posedge clk_sys);
        #1;
        `CHK("pull_free", 1'b0, pull20)
    endtask : t_pin20

    // timer pin routing, both timers enabled, then timer 0 and timer 1 disabled in turn
    task automatic t_timers();
        t0_lvl <= 1'b1;
        t1_lvl <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK("t0_pad", 1'b1, t0_pad)
        `CHK("t1_pad", 1'b1, t1_pad)
        wr(PCR_PAGE0, 8'hB5, 8'h08);
        `CHK("t0_oe_off", 1'b0, t0e)
        `CHK("t0_pad_off", 1'b0, t0_pad)
        `CHK("t1_still", 1'b1, t1e & t1o)
        t1_lvl <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK("t1_follow", 1'b0, t1_pad)
        wr(PCR_PAGE0, 8'hB5, 8'h00);
        `CHK("t1_oe_off", 1'b0, t1e)
    endtask : t_timers

    // ************************************
    // main sequence
    // ************************************
    initial begin
        rst_b = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00; sfr_wr = 1'b0; sfr_rd = 1'b0;
        sfr_page = 1'b0; fuse_lvl = 1'b0; t0_lvl = 1'b0; t1_lvl = 1'b0;
        error_cnt = 0; total_checks = 0; cycles = 0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_slew0();
        t_port1();
        t_pin20();
        t_timers();
        tally_and_finish();
    end
endmodule : test_port_pin_config_regs
